// *** logic/omd_decoder.sv ***
// On-chip memory map decoder with block configuration and space selects.
//
// Operation
// - Base: 544 words, only configurable block swaps.
// - Configurable block: data pages 4-5, program FF00h.
// - Second block pages 6-7; scratch top of page0.
// - Pages 1-3, rest of page 0 reserved.
// - Space selects, strobe low only off-chip.
// - Data command maps data; program command maps program.
// - Reset leaves configurable block as data.
// - Remap after one fetch from internal RAM.
// - ROM variant: two fetches when fetching externally.
// - Map pin high external low ROM first 4K.
// - Data on-chip in lowest 1K, rest external.
// - Ready stretches external; internal no wait.
// - Large: 256-word ROM, vectors in ROM, test words reserved.
// - Large micro mode: 0-FFFh internal, 100h-FFFh reserved.
// - Large: FA00h-FFFFh internal if any block program.
// - Large: external data starts at 800h.
// - Large data blocks at 200h, 400h, 600h.
// - Large program blocks at FA00h, FC00h, FE00h.
`timescale 1ns/1ns

module omd_decoder
	import omd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire omd_variant_t variant,
	input wire logic rom_map_select_pin,
	input wire logic fetch_strobe,
	input wire logic configure_block_as_data_cmd,
	input wire logic configure_block_as_program_cmd,
	input wire logic [2:0] block_select,
	input wire omd_req_t req,
	input wire logic ready,
	output omd_sel_t sel,
	output logic [2:0] block_is_program,
	output logic program_space_select_n,
	output logic data_space_select_n,
	output logic io_space_select_n,
	output logic external_access_strobe_n,
	output logic access_done,
	output logic [15:0] ext_addr
);

	// Pending configuration and the fetch countdown that applies it.
	logic [2:0] pend_cfg;
	logic [1:0] remap_cnt;
	logic fetch_internal;
	logic [1:0] remap_dly;
	logic next_fetch_internal;
	omd_sel_t next_sel;
	logic is_ext;
	logic next_pending_busy;

	// Inclusive range check used throughout the decoder.
	function automatic logic in_rng(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	// Decode one address against a configuration into a one-hot target.
	function automatic omd_sel_t decode(input omd_variant_t v,
		input logic [1:0] sp, input logic [15:0] a,
		input logic [2:0] prg, input logic mp);
		omd_sel_t s;
		s = '0;
		if (sp == OMD_SP_IO) begin
			s.ext = 1'b1;
		end else if (v == OMD_VAR_LARGE && sp == OMD_SP_DATA) begin
			// Data blocks take pages 4 to 15 while set as data.
			if (in_rng(a, OMD_SCR_LO, OMD_SCR_HI))
				s.scratch_blk = 1'b1;
			else if (!prg[OMD_IDX_CFG] && in_rng(a, OMD_L_CFG_LO, OMD_L_CFG_HI))
				s.config_blk = 1'b1;
			else if (!prg[OMD_IDX_SEC] && in_rng(a, OMD_L_SEC_LO, OMD_L_SEC_HI))
				s.second_blk = 1'b1;
			else if (!prg[OMD_IDX_EXTRA] && in_rng(a, OMD_L_EXT_LO, OMD_L_EXT_HI))
				s.extra_blk = 1'b1;
			else if (a >= OMD_L_DATA_EXT)
				s.ext = 1'b1;
			else
				s.rsvd = 1'b1;
		end else if (v == OMD_VAR_LARGE) begin
			// Program space, large-RAM variant.
			if (!mp && a <= OMD_L_P_INT_TOP) begin
				// Test words and the space above the ROM are internal but reserved.
				if (a > OMD_L_ROM_TOP || a >= OMD_L_TEST_LO)
					s.rsvd = 1'b1;
				else
					s.rom = 1'b1;
			end else if (|prg && a >= OMD_L_P_CFG_LO) begin
				if (prg[OMD_IDX_CFG] && a <= OMD_L_P_CFG_HI)
					s.config_blk = 1'b1;
				else if (prg[OMD_IDX_SEC] && in_rng(a, OMD_L_P_SEC_LO, OMD_L_P_SEC_HI))
					s.second_blk = 1'b1;
				else if (prg[OMD_IDX_EXTRA] && a >= OMD_L_P_EXT_LO)
					s.extra_blk = 1'b1;
				else
					s.rsvd = 1'b1;
			end else begin
				s.ext = 1'b1;
			end
		end else if (sp == OMD_SP_DATA) begin
			// Base data map: everything under 1K is on-chip or reserved.
			if (in_rng(a, OMD_SCR_LO, OMD_SCR_HI))
				s.scratch_blk = 1'b1;
			else if (!prg[OMD_IDX_CFG] && in_rng(a, OMD_B_CFG_LO, OMD_B_CFG_HI))
				s.config_blk = 1'b1;
			else if (in_rng(a, OMD_B_SEC_LO, OMD_B_SEC_HI))
				s.second_blk = 1'b1;
			else if (a <= OMD_DATA_INT_TOP)
				s.rsvd = 1'b1;
			else
				s.ext = 1'b1;
		end else begin
			// Base program map. The oldest variant has no ROM.
			if (prg[OMD_IDX_CFG] && a >= OMD_B_PRG_LO)
				s.config_blk = 1'b1;
			else if (v == OMD_VAR_ROM && !mp && a <= OMD_ROM_TOP)
				s.rom = 1'b1;
			else
				s.ext = 1'b1;
		end
		decode = s;
	endfunction : decode

	// Registered one-hot selection of the current request.
	always_comb begin
		next_sel = decode(variant, req.space, req.addr, block_is_program,
			rom_map_select_pin);
		is_ext = req.valid && next_sel.ext;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel <= '0;
			ext_addr <= '0;
		end else begin
			sel <= req.valid ? next_sel : '0;
			ext_addr <= is_ext ? req.addr : ext_addr;
		end
	end

	// Where the last fetch came from decides the remap delay.
	always_comb begin
		next_fetch_internal = req.valid && req.space == OMD_SP_PROG &&
			!next_sel.ext && !next_sel.rom;
		if (fetch_internal)
			remap_dly = OMD_DLY_INT;
		else if (variant == OMD_VAR_OLDEST)
			remap_dly = OMD_DLY_EXT_OLD;
		else
			remap_dly = OMD_DLY_EXT_ROM;
		next_pending_busy = remap_cnt != 2'h0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			fetch_internal <= 1'b0;
		else if (fetch_strobe)
			fetch_internal <= next_fetch_internal;
	end

	// Configuration commands load a pending value; fetches count it in.
	// A command during a countdown restarts it with the newest value.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			block_is_program <= '0;
			pend_cfg <= '0;
			remap_cnt <= '0;
		end else if (configure_block_as_program_cmd ||
			configure_block_as_data_cmd) begin
			// Base variants only have the configurable block to swap.
			if (variant == OMD_VAR_LARGE) begin
				pend_cfg <= configure_block_as_program_cmd ?
					(block_is_program | block_select) :
					(block_is_program & ~block_select);
			end else begin
				pend_cfg <= {2'h0, configure_block_as_program_cmd};
			end
			remap_cnt <= remap_dly;
		end else if (fetch_strobe && next_pending_busy) begin
			remap_cnt <= remap_cnt - 2'h1;
			if (remap_cnt == 2'h1)
				block_is_program <= pend_cfg;
		end
	end

	// Selects drop low only for an off-chip cycle of their own space.
	always_comb begin
		program_space_select_n = !(is_ext && req.space == OMD_SP_PROG);
		data_space_select_n = !(is_ext && req.space == OMD_SP_DATA);
		io_space_select_n = !(is_ext && req.space == OMD_SP_IO);
		external_access_strobe_n = !is_ext;
		// Internal cycles never wait; external ones wait for ready.
		access_done = req.valid && (!next_sel.ext || ready);
	end

endmodule : omd_decoder

// *** pkg/omd_pkg.sv ***
// Package for the on-chip memory map decoder: address limits and types.
package omd_pkg;

	// Device variant selection.
	typedef enum logic [1:0] {
		OMD_VAR_OLDEST,
		OMD_VAR_ROM,
		OMD_VAR_LARGE
	} omd_variant_t;

	// Decode targets, one bit each in the one-hot selection.
	typedef struct packed {
		logic ext;
		logic rsvd;
		logic rom;
		logic extra_blk;
		logic scratch_blk;
		logic second_blk;
		logic config_blk;
	} omd_sel_t;

	// Bus request from the core.
	typedef struct packed {
		logic valid;
		logic [1:0] space;
		logic [15:0] addr;
	} omd_req_t;

	localparam logic [1:0] OMD_SP_PROG = 2'h0;
	localparam logic [1:0] OMD_SP_DATA = 2'h1;
	localparam logic [1:0] OMD_SP_IO = 2'h2;

	// Base variant, data space.
	localparam logic [15:0] OMD_SCR_LO = 16'h0060;
	localparam logic [15:0] OMD_SCR_HI = 16'h007F;
	localparam logic [15:0] OMD_B_CFG_LO = 16'h0200;
	localparam logic [15:0] OMD_B_CFG_HI = 16'h02FF;
	localparam logic [15:0] OMD_B_SEC_LO = 16'h0300;
	localparam logic [15:0] OMD_B_SEC_HI = 16'h03FF;
	localparam logic [15:0] OMD_DATA_INT_TOP = 16'h03FF;
	// Base variant, program space.
	localparam logic [15:0] OMD_B_PRG_LO = 16'hFF00;
	localparam logic [15:0] OMD_ROM_TOP = 16'h0FFF;

	// Large-RAM variant, data space.
	localparam logic [15:0] OMD_L_CFG_LO = 16'h0200;
	localparam logic [15:0] OMD_L_CFG_HI = 16'h03FF;
	localparam logic [15:0] OMD_L_SEC_LO = 16'h0400;
	localparam logic [15:0] OMD_L_SEC_HI = 16'h05FF;
	localparam logic [15:0] OMD_L_EXT_LO = 16'h0600;
	localparam logic [15:0] OMD_L_EXT_HI = 16'h07FF;
	localparam logic [15:0] OMD_L_DATA_EXT = 16'h0800;
	// Large-RAM variant, program space.
	localparam logic [15:0] OMD_L_P_CFG_LO = 16'hFA00;
	localparam logic [15:0] OMD_L_P_CFG_HI = 16'hFBFF;
	localparam logic [15:0] OMD_L_P_SEC_LO = 16'hFC00;
	localparam logic [15:0] OMD_L_P_SEC_HI = 16'hFDFF;
	localparam logic [15:0] OMD_L_P_EXT_LO = 16'hFE00;
	localparam logic [15:0] OMD_L_ROM_TOP = 16'h00FF;
	localparam logic [15:0] OMD_L_TEST_LO = 16'h00F4;
	localparam logic [15:0] OMD_L_VEC_TOP = 16'h001F;
	localparam logic [15:0] OMD_L_P_INT_TOP = 16'h0FFF;

	// Remap delays in fetch cycles.
	localparam logic [1:0] OMD_DLY_INT = 2'h1;
	localparam logic [1:0] OMD_DLY_EXT_ROM = 2'h2;
	localparam logic [1:0] OMD_DLY_EXT_OLD = 2'h1;

	// Block configuration index values for the large-RAM variant.
	localparam int OMD_IDX_CFG = 0;
	localparam int OMD_IDX_SEC = 1;
	localparam int OMD_IDX_EXTRA = 2;

endpackage : omd_pkg

// *** verif/omd_ext_mem.sv ***
// External memory model that ends off-chip cycles after a set wait.
`timescale 1ns/1ns
module omd_ext_mem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe_n,
	input wire logic [1:0] wait_states,
	output logic ready
);
	logic [1:0] cnt;
	// Ready drops with the strobe, so a stale answer never ends a cycle.
	assign ready = !strobe_n && cnt == wait_states;
	// The wait count restarts after every completed cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt <= 2'h0;
		else if (strobe_n || ready)
			cnt <= 2'h0;
		else
			cnt <= cnt + 2'h1;
	end
endmodule : omd_ext_mem

// *** verif/omd_chk.sv ***
// Checker of decode and timing relations at the decoder ports.
`timescale 1ns/1ns
module omd_chk
	import omd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fetch_strobe,
	input wire omd_req_t req,
	input wire logic ready,
	input wire omd_sel_t sel,
	input wire logic [2:0] block_is_program,
	input wire logic data_space_select_n,
	input wire logic io_space_select_n,
	input wire logic external_access_strobe_n,
	input wire logic access_done
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// An off-chip cycle, and a data access to the configurable block.
	sequence s_ext;
		req.valid && !external_access_strobe_n;
	endsequence
	sequence s_cfg_data;
		req.valid && req.space == OMD_SP_DATA && req.addr[15:8] == 8'h02
			&& !block_is_program[0];
	endsequence
	a_sel_onehot: assert property (req.valid |=> $onehot(sel))
		else $error("selection not one-hot");
	a_strobe_ext: assert property (s_ext |=> sel.ext)
		else $error("strobe on internal cycle");
	a_io_offchip: assert property (req.valid && req.space == OMD_SP_IO
		|-> !io_space_select_n && !external_access_strobe_n)
		else $error("io cycle not external");
	a_int_nowait: assert property (req.valid && external_access_strobe_n
		|-> access_done) else $error("internal cycle waited");
	a_ext_ready: assert property (s_ext |-> access_done == ready)
		else $error("external cycle ignores ready");
	a_data_high: assert property (req.valid && req.space == OMD_SP_DATA
		&& req.addr[15:11] != 5'h00 |-> !data_space_select_n)
		else $error("high data not external");
	a_cfg_fetch: assert property ($changed(block_is_program)
		|-> $past(fetch_strobe)) else $error("remap without fetch");
	a_cfg_data: assert property (s_cfg_data |=> sel.config_blk)
		else $error("block not decoded as data");
endmodule : omd_chk

bind omd_decoder omd_chk u_chk (.clk, .rst_n, .fetch_strobe, .req, .ready,
	.sel, .block_is_program, .data_space_select_n, .io_space_select_n,
	.external_access_strobe_n, .access_done);

// *** verif/onchip_memory_map_decoder_tb.sv ***
// Testbench for the on-chip memory map decoder.
`timescale 1ns/1ns
module onchip_memory_map_decoder_tb
	import omd_pkg::*;
;
	logic clk = 1'h0, rst_n, rom_map_select_pin = 1'h0, fetch_strobe;
	logic configure_block_as_data_cmd = 1'h0, ready;
	logic configure_block_as_program_cmd = 1'h0;
	logic [2:0] block_select = 3'h1, block_is_program;
	logic [1:0] ws = 2'h0;
	logic program_space_select_n, data_space_select_n;
	logic io_space_select_n, external_access_strobe_n, access_done;
	logic done;
	logic [15:0] ext_addr;
	omd_variant_t variant;
	omd_req_t req;
	omd_sel_t sel, s;
	int errors = 0, cmp_count = 0, cyc;
	omd_decoder dut (.clk, .rst_n, .variant, .rom_map_select_pin,
		.fetch_strobe, .configure_block_as_data_cmd, .req, .ready,
		.configure_block_as_program_cmd, .block_select, .sel,
		.block_is_program, .program_space_select_n, .data_space_select_n,
		.io_space_select_n, .external_access_strobe_n, .access_done,
		.ext_addr);
	omd_ext_mem mem (.clk, .rst_n, .strobe_n(external_access_strobe_n),
		.wait_states(ws), .ready);
	// Free-running 50 MHz clock.
	always #10 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk
	// Space 0 is program (each one a fetch), 1 data, 2 io; held to done.
	// Done is taken at the falling edge, so it is the value that the
	// next rising edge samples, not one already moved by that edge.
	task automatic dec(input logic [1:0] sp, input logic [15:0] a,
		input logic [6:0] exp);
		req = '{1'h1, sp, a};
		fetch_strobe = sp == 2'h0;
		cyc = 0;
		do begin
			@(negedge clk);
			done = access_done;
			@(posedge clk);
			cyc++;
		end while (done !== 1'h1 && cyc < 9);
		#1;
		s = sel;
		chk(16'(s), 16'(exp));
	endtask : dec
	// One configure pulse with no request, so it is not also a fetch.
	task automatic cmd(input logic p);
		req.valid = 1'h0;
		fetch_strobe = 1'h0;
		configure_block_as_program_cmd = p;
		configure_block_as_data_cmd = !p;
		@(posedge clk);
		#1;
		configure_block_as_program_cmd = 1'h0;
		configure_block_as_data_cmd = 1'h0;
	endtask : cmd
	// The variant is a strap, so it only changes under reset.
	task automatic rst(input omd_variant_t v);
		rst_n = 1'h0;
		req = '0;
		fetch_strobe = 1'h0;
		variant = v;
		repeat (5) @(posedge clk);
		#1;
		chk(16'(block_is_program), 16'h0000);
		rst_n = 1'h1;
	endtask : rst
	task automatic t_base;
		dec(2'h1, 16'h0200, 7'h01);
		chk(16'(cyc), 16'h0001);
		dec(2'h1, 16'h0300, 7'h02);
		dec(2'h1, 16'h0060, 7'h04);
		dec(2'h1, 16'h0100, 7'h20);
		dec(2'h2, 16'h0200, 7'h40);
		dec(2'h0, 16'h0010, 7'h10);
		rom_map_select_pin = 1'h1;
		dec(2'h0, 16'h0010, 7'h40);
		chk(16'(program_space_select_n), 16'h0000);
		ws = 2'h2;
		dec(2'h1, 16'h8000, 7'h40);
		chk(16'(cyc), 16'h0003);
		chk(ext_addr, 16'h8000);
		ws = 2'h0;
		$display("base map done");
	endtask : t_base
	task automatic t_remap;
		dec(2'h0, 16'hFEFD, 7'h40);
		cmd(1'h1);
		dec(2'h0, 16'hFEFE, 7'h40);
		chk(16'(block_is_program), 16'h0000);
		dec(2'h0, 16'hFEFF, 7'h40);
		chk(16'(block_is_program), 16'h0001);
		dec(2'h0, 16'hFF00, 7'h01);
		cmd(1'h0);
		dec(2'h0, 16'hFF01, 7'h01);
		chk(16'(block_is_program), 16'h0000);
		dec(2'h0, 16'hFF02, 7'h40);
		$display("remap done");
	endtask : t_remap
	task automatic t_large;
		rst(OMD_VAR_LARGE);
		rom_map_select_pin = 1'h0;
		dec(2'h0, 16'h0010, 7'h10);
		cmd(1'h1);
		dec(2'h0, 16'h0011, 7'h10);
		dec(2'h0, 16'h0012, 7'h10);
		chk(16'(block_is_program), 16'h0001);
		dec(2'h0, 16'hFA00, 7'h01);
		dec(2'h1, 16'h0200, 7'h20);
		dec(2'h1, 16'h0400, 7'h02);
		dec(2'h1, 16'h0600, 7'h08);
		dec(2'h1, 16'h0800, 7'h40);
		dec(2'h0, 16'h00F4, 7'h20);
		dec(2'h0, 16'h0100, 7'h20);
		dec(2'h0, 16'h1000, 7'h40);
		cmd(1'h0);
		dec(2'h0, 16'h1001, 7'h40);
		dec(2'h0, 16'h1002, 7'h40);
		dec(2'h0, 16'hFA00, 7'h40);
		$display("large map done");
	endtask : t_large
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	// The tests need under 100 cycles; 2000 cycles means a hang.
	initial begin
		#40000;
		errors++;
		print_verdict();
	end
	// Main sequence.
	initial begin
		rst(OMD_VAR_ROM);
		t_base();
		t_remap();
		t_large();
		print_verdict();
	end
endmodule : onchip_memory_map_decoder_tb
